// ==== rtl/ibpcp_regs.vh ====
// Purpose: Constants for the I2C book/page control port
// Assumes: Included by ibpcp_port.v and by the testbench
// Notes:   Offsets are register indices within a page
`ifndef IBPCP_REGS_VH
`define IBPCP_REGS_VH
`define IBPCP_ADDR_FIXED     5'h13
`define IBPCP_IDX_PAGE_SEL   7'h00
`define IBPCP_IDX_BOOK_SEL   7'h7F
`define IBPCP_PAGE_RST       8'h00
`define IBPCP_PAGE_ZERO      8'h00
`define IBPCP_BOOK_RST       8'h00
`define IBPCP_DATA_RST       8'h00
`define IBPCP_IDX_LAST       7'h7F
`define IBPCP_IDX_FIRST      7'h00
`endif

// ==== rtl/ibpcp_port.v ====
// Purpose: I2C target control port with book and page selection
// Assumes: SCL and SDA are sampled by core_clk through two flip-flops
// Notes:   Registers other than the selectors live in a local page array
// Notes on behaviour
// - Target only, standard and fast mode.
// - Page zero index 0x7f selects book.
// - Index 0x00 selects page, any value.
// - Address is 10011 plus two pin bits.
// - Pins give address bytes 0x98 to 0x9E.
// - Acknowledge own address.
// - Auto-increment always on.
// - Increment stays inside current page.
// - Index 0x7F wraps to 0x00.
// - Never drive start or stop.
// - Store write byte, then index plus one.
// - Read after index write and repeated start.
// - Read increments index after each byte.
// - Configuration only through this port.
`include "ibpcp_regs.vh"
module ibpcp_port (
    input  wire       core_clk,              // System clock, 10 MHz
    input  wire       rst,                   // Asynchronous reset, active high
    input  wire       sclIn,                 // Bus clock line level
    input  wire       sdaIn,                 // Bus data line level
    input  wire       addr_select_pin_low,   // Address select, bit 1 of address byte
    input  wire       addr_select_pin_high,  // Address select, bit 2 of address byte
    output reg        sdaOut,                // Data line drive value, always low
    output reg        sdaOe,                 // Data line drive enable
    output reg  [7:0] pageSel,               // Selected page
    output reg  [7:0] bookSel,               // Selected book
    output reg        busyOut                // Transfer in progress
);
    localparam ST_IDLE  = 3'd0;  // Waiting for start
    localparam ST_ADDR  = 3'd1;  // Shifting address byte
    localparam ST_AACK  = 3'd2;  // Acknowledging address
    localparam ST_WBYTE = 3'd3;  // Receiving index or data
    localparam ST_WACK  = 3'd4;  // Acknowledging received byte
    localparam ST_RBYTE = 3'd5;  // Transmitting byte
    localparam ST_RACK  = 3'd6;  // Sampling controller ack

    // Next index within the page, wraps at the top
    function [6:0] nextIdx;
        input [6:0] cur;
        begin
            if (cur == `IBPCP_IDX_LAST)
                nextIdx = `IBPCP_IDX_FIRST;
            else
                nextIdx = cur + 7'h01;
        end
    endfunction

    // Book selector exists at the top index of page zero only
    function bookHit;
        input [6:0] cur;
        input [7:0] page;
        begin
            bookHit = (cur == `IBPCP_IDX_BOOK_SEL) && (page == `IBPCP_PAGE_ZERO);
        end
    endfunction

    reg  [1:0] sclSync_r;   // SCL synchroniser
    reg  [1:0] sdaSync_r;   // SDA synchroniser
    reg  [1:0] adrSync_r;   // Pin synchroniser stage 1
    reg  [1:0] adrSync2_r;  // Pin synchroniser stage 2
    reg        sclD_r;      // Delayed SCL for edges
    reg        sdaD_r;      // Delayed SDA for edges
    reg  [2:0] state_r;     // Protocol state
    reg  [3:0] bitCnt_r;    // Bit counter
    reg  [7:0] shift_r;     // Shift register
    reg        haveIdx_r;   // Index byte received in this write
    reg        rdMode_r;    // Current address read bit
    reg  [6:0] idx_r;       // Register index
    reg  [7:0] mem [0:127]; // Ordinary registers of current page
    integer    i;           // Loop index

    wire scl     = sclSync_r[1];
    wire sda     = sdaSync_r[1];
    wire sclRise = scl & ~sclD_r;
    wire sclFall = ~scl & sclD_r;
    wire startC  = scl & sclD_r & ~sda & sdaD_r; // Start or repeated start
    wire stopC   = scl & sclD_r & sda & ~sdaD_r; // Stop
    wire addrHit = (shift_r[7:3] == `IBPCP_ADDR_FIXED) && (shift_r[2:1] == adrSync2_r);

    // Readback of the byte at the current index
    wire [7:0] rdByte = (idx_r == `IBPCP_IDX_PAGE_SEL) ? pageSel :
                        bookHit(idx_r, pageSel) ? bookSel : mem[idx_r];

    // Input synchronisers
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclSync_r  <= 2'h3;
            sdaSync_r  <= 2'h3;
            adrSync_r  <= 2'h0;
            adrSync2_r <= 2'h0;
            sclD_r     <= 1'b1;
            sdaD_r     <= 1'b1;
        end else begin
            sclSync_r  <= {sclSync_r[0], sclIn};
            sdaSync_r  <= {sdaSync_r[0], sdaIn};
            adrSync_r  <= {addr_select_pin_high, addr_select_pin_low};
            adrSync2_r <= adrSync_r;
            sclD_r     <= scl;
            sdaD_r     <= sda;
        end
    end

    // Target protocol engine; never drives start or stop
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            bitCnt_r  <= 4'h0;
            shift_r   <= 8'h00;
            haveIdx_r <= 1'b0;
            rdMode_r  <= 1'b0;
            idx_r     <= `IBPCP_IDX_FIRST;
            sdaOe     <= 1'b0;
            pageSel   <= `IBPCP_PAGE_RST;
            bookSel   <= `IBPCP_BOOK_RST;
            busyOut   <= 1'b0;
            for (i = 0; i < 128; i = i + 1)
                mem[i] <= `IBPCP_DATA_RST;
        end else if (startC) begin
            // Start: begin address byte, keep index for reads
            state_r  <= ST_ADDR;
            bitCnt_r <= 4'h0;
            sdaOe    <= 1'b0;
            busyOut  <= 1'b1;
        end else if (stopC) begin
            state_r <= ST_IDLE;
            sdaOe   <= 1'b0;
            busyOut <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    sdaOe <= 1'b0;
                end
                ST_ADDR: begin
                    if (sclRise) begin
                        shift_r  <= {shift_r[6:0], sda};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (sclFall && bitCnt_r == 4'h8) begin
                        if (addrHit) begin
                            sdaOe    <= 1'b1;
                            rdMode_r <= shift_r[0];
                            state_r  <= ST_AACK;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (sclFall) begin
                        bitCnt_r  <= 4'h0;
                        haveIdx_r <= 1'b0;
                        if (rdMode_r) begin
                            shift_r <= rdByte;
                            sdaOe   <= ~rdByte[7];
                            state_r <= ST_RBYTE;
                        end else begin
                            sdaOe   <= 1'b0;
                            state_r <= ST_WBYTE;
                        end
                    end
                end
                ST_WBYTE: begin
                    if (sclRise) begin
                        shift_r  <= {shift_r[6:0], sda};
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (sclFall && bitCnt_r == 4'h8) begin
                        sdaOe   <= 1'b1;
                        state_r <= ST_WACK;
                        if (!haveIdx_r) begin
                            idx_r     <= shift_r[6:0];
                            haveIdx_r <= 1'b1;
                        end else begin
                            if (idx_r == `IBPCP_IDX_PAGE_SEL)
                                pageSel <= shift_r;
                            else if (bookHit(idx_r, pageSel))
                                bookSel <= shift_r;
                            else
                                mem[idx_r] <= shift_r;
                            idx_r <= nextIdx(idx_r);
                        end
                    end
                end
                ST_WACK: begin
                    if (sclFall) begin
                        sdaOe    <= 1'b0;
                        bitCnt_r <= 4'h0;
                        state_r  <= ST_WBYTE;
                    end
                end
                ST_RBYTE: begin
                    if (sclFall) begin
                        if (bitCnt_r == 4'h7) begin
                            sdaOe   <= 1'b0;
                            idx_r   <= nextIdx(idx_r);
                            state_r <= ST_RACK;
                        end else begin
                            sdaOe   <= ~shift_r[6];
                            shift_r <= {shift_r[6:0], 1'b0};
                        end
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end
                end
                ST_RACK: begin
                    if (sclRise) begin
                        if (sda) begin
                            state_r <= ST_IDLE;
                        end else begin
                            bitCnt_r <= 4'h0;
                        end
                    end else if (sclFall) begin
                        shift_r <= rdByte;
                        sdaOe   <= ~rdByte[7];
                        state_r <= ST_RBYTE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    sdaOe   <= 1'b0;
                end
            endcase
        end
    end

    // Pull-down drive value for open-drain data line
    always @(posedge core_clk or posedge rst) begin
        if (rst)
            sdaOut <= 1'b0;
        else
            sdaOut <= 1'b0;
    end
endmodule

// ==== testbench/ibpcp_checker.sv ====
// Purpose: Assertions on the book/page control port
// Assumes: Bound to ibpcp_port
// Notes:   Bus events read from raw line levels
module ibpcp_checker (
    input logic       core_clk,             // Clock
    input logic       rst,                  // Reset
    input logic       sclIn,                // Bus clock
    input logic       sdaIn,                // Bus data
    input logic       addr_select_pin_low,  // Pin
    input logic       addr_select_pin_high, // Pin
    input logic       sdaOut,               // Drive value
    input logic       sdaOe,                // Drive enable
    input logic [7:0] pageSel,              // Page
    input logic [7:0] bookSel,              // Book
    input logic       busyOut               // Busy
);
    timeunit 1ns / 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_od; sdaOut == 1'b0; endproperty
    a_od: assert property (p_od) else $error("data driven high");
    property p_oeLow; $changed(sdaOe) |-> !sclIn; endproperty
    a_oeLow: assert property (p_oeLow) else $error("data moved with clock high");
    property p_idle; !busyOut |-> !sdaOe; endproperty
    a_idle: assert property (p_idle) else $error("drive outside transfer");
    property p_busyUp; ($fell(sdaIn) && sclIn && $past(sclIn)) |-> ##[1:5] busyOut; endproperty
    a_busyUp: assert property (p_busyUp) else $error("start missed");
    property p_busyDn; ($rose(sdaIn) && sclIn && $past(sclIn)) |-> ##[1:5] !busyOut; endproperty
    a_busyDn: assert property (p_busyDn) else $error("stop missed");
    property p_ackHold; $rose(sdaOe) |=> sdaOe [*4]; endproperty
    a_ackHold: assert property (p_ackHold) else $error("drive too short");
    property p_page; $changed(pageSel) |-> busyOut; endproperty
    a_page: assert property (p_page) else $error("page moved idle");
    property p_book; $changed(bookSel) |-> pageSel == 8'h00; endproperty
    a_book: assert property (p_book) else $error("book moved off page zero");
    c_ack: cover property ($rose(sdaOe));
    c_book: cover property ($changed(bookSel));
    c_stop: cover property ($fell(busyOut));
endmodule
bind ibpcp_port ibpcp_checker chk_u (.core_clk(core_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
    .addr_select_pin_low(addr_select_pin_low), .addr_select_pin_high(addr_select_pin_high),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .pageSel(pageSel), .bookSel(bookSel), .busyOut(busyOut));

// ==== testbench/ibpcp_host_model.sv ====
// Purpose: Bus controller model for the clock and data lines
// Assumes: Lines pulled up; data drive of 1 releases
// Notes:   Nine core clocks per bit
module ibpcp_host_model (
    input  logic clk,    // Core clock
    input  logic sdaBus, // Wired data line
    output logic scl,    // Clock drive
    output logic sda     // Data drive
);
    timeunit 1ns / 1ns;
    initial scl = 1'b1;
    initial sda = 1'b1;
    // Start or repeated start, clock idles high
    task automatic startC();
        @(posedge clk) sda <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
    endtask
    task automatic stopC();
        @(posedge clk) sda <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // Low 500 ns, setup 400 ns
    task automatic bitIo(input logic b, output logic r);
        @(posedge clk) sda <= b;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (2) @(posedge clk);
        #1 r = sdaBus;
        repeat (2) @(posedge clk);
        scl <= 1'b0;
    endtask
    // Eight bits first from the top, then the ninth
    task automatic byteIo(input logic [7:0] d, input logic last, output logic [7:0] q, output logic r);
        for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
        bitIo(last, r);
    endtask
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the book/page control port
// Assumes: Host model drives the bus
// Notes:   Seed fixed
`include "ibpcp_regs.vh"
module testbench;
    timeunit 1ns / 1ns;
    logic       coreClk = 1'b0;      // Clock
    logic       rst = 1'b1;          // Reset
    logic       pinLo = 1'b0;        // Address pins
    logic       pinHi = 1'b0;
    logic       scl, sda, sdaOe, ack; // Bus
    logic       sdaDrv, busy;         // Drive value and busy flag
    logic [7:0] q, v, pageSel, bookSel;
    logic [7:0] dq [4];              // Sent
    logic [7:0] rq [4];              // Read
    int         mismatches = 0;
    int         checked = 0;
    wire        sdaBus = sda & (~sdaOe | sdaDrv); // Pull-up, open drain
    always #50 coreClk = ~coreClk;
    ibpcp_host_model host_u (.clk(coreClk), .sdaBus(sdaBus), .scl(scl), .sda(sda));
    ibpcp_port dut_u (.core_clk(coreClk), .rst(rst), .sclIn(scl), .sdaIn(sdaBus),
        .addr_select_pin_low(pinLo), .addr_select_pin_high(pinHi), .sdaOut(sdaDrv), .sdaOe(sdaOe),
        .pageSel(pageSel), .bookSel(bookSel), .busyOut(busy));
    function automatic logic [7:0] devAddr(input logic rd);
        return {`IBPCP_ADDR_FIXED, pinHi, pinLo, rd};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic head(input logic [7:0] idx);
        host_u.startC();
        host_u.byteIo(devAddr(1'b0), 1'b1, q, ack);
        cmp({7'h0, ack}, 8'h00, "address ack");
        cmp({7'h0, busy}, 8'h01, "busy in transfer");
        cmp({7'h0, sdaDrv}, 8'h00, "drive level");
        host_u.byteIo(idx, 1'b1, q, ack);
        cmp({7'h0, ack}, 8'h00, "index ack");
    endtask
    task automatic wr(input logic [7:0] idx, input int n);
        head(idx);
        for (int i = 0; i < n; i++) host_u.byteIo(dq[i], 1'b1, q, ack);
        host_u.stopC();
        cmp({7'h0, ack}, 8'h00, "data ack");
        cmp({7'h0, busy}, 8'h00, "busy after stop");
    endtask
    task automatic rd(input logic [7:0] idx, input int n);
        head(idx);
        host_u.startC();
        host_u.byteIo(devAddr(1'b1), 1'b1, q, ack);
        cmp({7'h0, ack}, 8'h00, "read address ack");
        for (int i = 0; i < n; i++) host_u.byteIo(8'hFF, i == n - 1, rq[i], ack);
        host_u.stopC();
        cmp({7'h0, busy}, 8'h00, "busy after read");
    endtask
    task close_out();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #5000000;
        mismatches++;
        close_out();
    end
    initial begin
        void'($urandom(59));
        repeat (2) @(posedge coreClk);
        rst <= 1'b0;
        repeat (4) @(posedge coreClk);
        // Every address against every pin setting
        for (int p = 0; p < 16; p++) begin
            {pinHi, pinLo} <= p[1:0];
            repeat (4) @(posedge coreClk);
            host_u.startC();
            host_u.byteIo({`IBPCP_ADDR_FIXED, p[3:2], 1'b0}, 1'b1, q, ack);
            host_u.stopC();
            cmp({7'h0, ack}, {7'h0, p[3:2] != p[1:0]}, "address match");
        end
        v = 8'($urandom) | 8'h01;
        dq[0] = v;
        wr(8'h00, 1);
        cmp(pageSel, v, "page");
        dq[0] = v ^ 8'h80;
        wr(8'h7F, 1);
        cmp(bookSel, 8'h00, "book off page zero");
        rd(8'h7F, 1);
        cmp(rq[0], dq[0], "top index off page zero");
        dq[0] = 8'h00;
        wr(8'h00, 1);
        dq[0] = 8'($urandom);
        dq[1] = v;
        dq[2] = 8'h00;
        wr(8'h7E, 3);
        cmp(bookSel, v, "book");
        rd(8'h7E, 3);
        cmp(rq[0], dq[0], "last but one");
        cmp(rq[1], v, "book read");
        cmp(rq[2], 8'h00, "wrapped index");
        dq[0] = 8'($urandom);
        wr(8'h85, 1);
        rd(8'h05, 1);
        cmp(rq[0], dq[0], "top index bit");
        for (int k = 0; k < 6; k++) begin
            v = 8'(1 + $urandom % 125);
            for (int i = 0; i < 3; i++) dq[i] = 8'($urandom);
            wr(v, 3);
            rd(v, 3);
            for (int i = 0; i < 3; i++) cmp(rq[i], dq[i], "burst");
        end
        close_out();
    end
endmodule
